// File: include/serial_config_mode_loader_pkg.sv
// Purpose: Types shared by the serial configuration loader.
// Assumes: Constants come from the _regs header.
// Notes: Mode codes follow the middle and low mode pins only.
package serial_config_mode_loader_pkg;
  typedef enum logic [1:0] {
    MODE_MASTER_SERIAL,
    MODE_TEST_PORT,
    MODE_BYTE_PARALLEL,
    MODE_SLAVE_SERIAL
  } load_mode_type;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_CLEAR,
    ST_FINAL,
    ST_WAIT_INIT,
    ST_LOAD,
    ST_CHECK,
    ST_RUN,
    ST_ERROR
  } seq_state_type;
endpackage : serial_config_mode_loader_pkg

// File: include/serial_config_mode_loader_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the loader.
// Assumes: System clock of 50 MHz; Avalon byte addresses, one 32-bit word per register.
// Notes: Rates are in kHz; half periods are counted in system clock cycles.
`ifndef SERIAL_CONFIG_MODE_LOADER_REGS_SVH
`define SERIAL_CONFIG_MODE_LOADER_REGS_SVH

`define CFG_ADDR_CTRL 4'h0
`define CFG_ADDR_STATUS 4'h4
`define CFG_ADDR_RATE 4'h8
`define CFG_ADDR_BITCNT 4'hc

`define CFG_CTRL_REPROG_BIT 0
`define CFG_ST_MODE_LSB 0
`define CFG_ST_PULLUP_BIT 3
`define CFG_ST_DONE_BIT 4
`define CFG_ST_CRCERR_BIT 5
`define CFG_ST_INIT_BIT 6
`define CFG_ST_STATE_LSB 8

`define CFG_CLK_KHZ 50000
`define CFG_SLOW_KHZ 2500
`define CFG_DEFAULT_KHZ 4000
`define CFG_MAX_KHZ 60000
`define CFG_SLOW_HALF (`CFG_CLK_KHZ / (2 * `CFG_SLOW_KHZ))
`define CFG_DEFAULT_HALF (`CFG_CLK_KHZ / (2 * `CFG_DEFAULT_KHZ))
`define CFG_MAX_RATE_HALF ((`CFG_CLK_KHZ + 2 * `CFG_MAX_KHZ - 1) / (2 * `CFG_MAX_KHZ))
`define CFG_MIN_HALF 2

`define CFG_RATE_BITS 8
`define CFG_CRC_BITS 16
`define CFG_CRC_POLY 16'h8005
`define CFG_CRC_INIT 16'hffff
`define CFG_CLEAR_CYCLES 64
`define CFG_FINAL_CYCLES 16
`define CFG_FRAME_BITS 3430400

`endif

// File: rtl/serial_config_mode_loader.sv
// Purpose: Mode decode, clear/load/check sequence and bit-serial loader with daisy chain.
// Assumes: All pins are asynchronous to I_CLK and pass two flip-flops first.
// Notes: Byte-parallel and test-port loading are decoded only; their datapaths live elsewhere.
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "serial_config_mode_loader_regs.svh"

// Function
// - Decode three mode pins into one of four loading modes plus pull-up choice.
// - Top mode pin low weakly pulls I/O up before loading; high leaves floating.
// - Test-port loading stays available; test-port mode only disables other loading modes.
// - Undriven mode pins read high through pull-ups, giving slave-serial mode.
// - Codes 111 and 011 select slave-serial loading.
// - Codes 000 and 100 select master-serial loading.
// - Slave source presents a bit before each external rising clock edge; device captures it.
// - After own frame completes, further incoming data goes out on the chain output.
// - Chain output changes only on the configuration clock rising edge and on reprogram, which sets it high.
// - Master mode generates, drives out and samples on its own configuration clock.
// - Master clock starts slow, then switches to the loaded rate, default 4 MHz.
// - Loaded rate may only raise the master clock frequency.
// - Selectable master clock rate never exceeds 60 MHz.
// - After reprogram returns high: clear memory, final pass, release init status.
// - Init held low externally postpones loading; no bit loads while it reads low.
// - Loaded data is CRC checked; failure drives init status low.
// - A passing check enters start-up and raises the completion pin.
// - Codes 101 and 001 select test-port loading.
// - Init status is open-drain, held low by the device while clearing.
module serial_config_mode_loader #(
  parameter int FRAME_BITS = `CFG_FRAME_BITS,
  parameter int CLEAR_CYCLES = `CFG_CLEAR_CYCLES,
  parameter int FINAL_CYCLES = `CFG_FINAL_CYCLES
) (
  input wire logic I_CLK, // System clock, 50 MHz.
  input wire logic I_RST, // Synchronous reset, high; acts as power-up.
  input wire logic I_MODE_PIN_HIGH, // Mode pin, top bit.
  input wire logic I_MODE_PIN_MID, // Mode pin, middle bit.
  input wire logic I_MODE_PIN_LOW, // Mode pin, low bit.
  input wire logic I_PROGRAM_N, // Reprogram request pin, low active.
  input wire logic I_INIT_N, // Init status pin level.
  input wire logic I_CONFIG_CLOCK, // Configuration clock pin level.
  input wire logic I_SERIAL_DATA, // Serial configuration data in.
  input wire logic [3:0] I_AVS_ADDRESS, // Avalon byte address.
  input wire logic I_AVS_READ, // Avalon read.
  input wire logic I_AVS_WRITE, // Avalon write.
  input wire logic [31:0] I_AVS_WRITEDATA, // Avalon write data.
  output logic [31:0] O_AVS_READDATA, // Avalon read data.
  output logic O_AVS_WAITREQUEST, // Avalon wait request.
  output logic O_INIT_N, // Init status output value, always low.
  output logic O_INIT_N_OE, // Init status driven low while high.
  output logic O_CONFIG_CLOCK, // Master configuration clock out.
  output logic O_CONFIG_CLOCK_OE, // Configuration clock driven while high.
  output logic O_CHAIN_DATA, // Daisy-chain data out.
  output logic O_DONE, // Completion pin.
  output logic O_IO_PULLUP, // Weak pull-up on I/O blocks before loading.
  output logic O_MODE_PULLUP, // Internal pull-up enable on mode pins.
  output logic O_TEST_PORT_EN // Test-port loading enable.
);
  import serial_config_mode_loader_pkg::*;

  function automatic load_mode_type decode_mode(input logic mid, input logic low);
    return load_mode_type'({mid, low});
  endfunction : decode_mode

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic bit_in);
    logic fb;
    fb = crc[15] ^ bit_in;
    return fb ? ({crc[14:0], 1'b0} ^ `CFG_CRC_POLY) : {crc[14:0], 1'b0};
  endfunction : crc_step

  localparam logic [7:0] SLOW_HALF = 8'(`CFG_SLOW_HALF);
  localparam logic [7:0] DEFAULT_HALF = 8'(`CFG_DEFAULT_HALF);
  localparam logic [7:0] MIN_HALF = 8'((`CFG_MAX_RATE_HALF > `CFG_MIN_HALF) ? `CFG_MAX_RATE_HALF : `CFG_MIN_HALF);
  localparam logic [31:0] FRAME_END = 32'(FRAME_BITS);
  localparam logic [31:0] DATA_END = 32'(FRAME_BITS - `CFG_CRC_BITS);
  localparam logic [31:0] RATE_END = 32'(`CFG_RATE_BITS);

  logic [2:0] mode_s1_q, mode_s2_q;
  logic prog_s1_q, prog_s2_q, init_s1_q, init_s2_q;
  logic config_clock_s1_q, config_clock_s2_q, config_clock_s3_q, din_s1_q, din_s2_q;
  seq_state_type state_q;
  logic [15:0] cyc_q;
  logic [2:0] mode_pins_q;
  load_mode_type mode_q;
  logic [31:0] bit_cnt_q;
  logic [15:0] crc_q, crc_rx_q;
  logic [7:0] rate_sr_q, half_q, div_q;
  logic mclk_q, crc_err_q, reprog_q, wait_q;
  logic master, serial_mode, clk_run, bit_edge, bit_take, frame_done, crc_ok;

  always_ff @(posedge I_CLK) begin
    mode_s1_q <= {I_MODE_PIN_HIGH, I_MODE_PIN_MID, I_MODE_PIN_LOW};
    mode_s2_q <= mode_s1_q;
    prog_s1_q <= I_PROGRAM_N;
    prog_s2_q <= prog_s1_q;
    init_s1_q <= I_INIT_N;
    init_s2_q <= init_s1_q;
    config_clock_s1_q <= I_CONFIG_CLOCK;
    config_clock_s2_q <= config_clock_s1_q;
    config_clock_s3_q <= config_clock_s2_q;
    din_s1_q <= I_SERIAL_DATA;
    din_s2_q <= din_s1_q;
  end

  assign master = (mode_q == MODE_MASTER_SERIAL);
  assign serial_mode = master || (mode_q == MODE_SLAVE_SERIAL);
  assign clk_run = master && (state_q == ST_LOAD || state_q == ST_CHECK || state_q == ST_RUN);
  // A master edge is the cycle the divider turns the clock high; a slave edge is a rise on the pin.
  assign bit_edge = master ? (clk_run && !mclk_q && div_q >= half_q - 8'h01) : (config_clock_s2_q && !config_clock_s3_q);
  assign bit_take = bit_edge && state_q == ST_LOAD && init_s2_q;
  assign frame_done = (bit_cnt_q == FRAME_END - 32'h1) && bit_take;
  assign crc_ok = (crc_rx_q == crc_q);

  // Sequencer.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_q <= ST_CLEAR;
      cyc_q <= 16'h0000;
      crc_err_q <= 1'b0;
    end else if (!prog_s2_q || reprog_q) begin
      state_q <= ST_HOLD;
      cyc_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_HOLD: begin
          state_q <= ST_CLEAR;
          cyc_q <= 16'h0000;
        end
        ST_CLEAR: begin
          cyc_q <= cyc_q + 16'h0001;
          if (cyc_q == 16'(CLEAR_CYCLES - 1)) begin
            state_q <= ST_FINAL;
            cyc_q <= 16'h0000;
          end
        end
        ST_FINAL: begin
          cyc_q <= cyc_q + 16'h0001;
          if (cyc_q == 16'(FINAL_CYCLES - 1)) begin
            state_q <= ST_WAIT_INIT;
            crc_err_q <= 1'b0;
          end
        end
        ST_WAIT_INIT: begin
          if (init_s2_q && serial_mode) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (frame_done) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (crc_ok) begin
            state_q <= ST_RUN;
          end else begin
            state_q <= ST_ERROR;
            crc_err_q <= 1'b1;
          end
        end
        ST_RUN: state_q <= ST_RUN;
        ST_ERROR: state_q <= ST_ERROR;
        default: state_q <= ST_HOLD;
      endcase
    end
  end

  // Mode is caught as the final clearing pass ends and held until the next reprogram.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mode_pins_q <= 3'h7;
      mode_q <= MODE_SLAVE_SERIAL;
    end else if (state_q == ST_FINAL && cyc_q == 16'(FINAL_CYCLES - 1)) begin
      mode_pins_q <= mode_s2_q;
      mode_q <= decode_mode(mode_s2_q[1], mode_s2_q[0]);
    end
  end

  // Frame bit counter and CRC over all bits ahead of the trailing check word.
  always_ff @(posedge I_CLK) begin
    if (I_RST || state_q != ST_LOAD) begin
      bit_cnt_q <= 32'h0;
      crc_q <= `CFG_CRC_INIT;
      crc_rx_q <= 16'h0000;
      rate_sr_q <= 8'h00;
    end else if (bit_take) begin
      bit_cnt_q <= bit_cnt_q + 32'h1;
      if (bit_cnt_q < DATA_END) begin
        crc_q <= crc_step(crc_q, din_s2_q);
      end else begin
        crc_rx_q <= {crc_rx_q[14:0], din_s2_q};
      end
      if (bit_cnt_q < RATE_END) begin
        rate_sr_q <= {rate_sr_q[6:0], din_s2_q};
      end
    end
  end

  // Master clock rate: slow until the rate field is in, then only ever faster.
  always_ff @(posedge I_CLK) begin
    if (I_RST || state_q == ST_HOLD || state_q == ST_CLEAR) begin
      half_q <= SLOW_HALF;
    end else if (state_q == ST_LOAD && bit_cnt_q == RATE_END && !bit_take) begin
      if (rate_sr_q == 8'h00) begin
        half_q <= (DEFAULT_HALF < half_q) ? DEFAULT_HALF : half_q;
      end else if (rate_sr_q < half_q) begin
        half_q <= (rate_sr_q < MIN_HALF) ? MIN_HALF : rate_sr_q;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST || !clk_run) begin
      div_q <= 8'h00;
      mclk_q <= 1'b0;
    end else if (div_q >= half_q - 8'h01) begin
      div_q <= 8'h00;
      mclk_q <= !mclk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Pin drivers.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_INIT_N <= 1'b0;
      O_INIT_N_OE <= 1'b1;
      O_CONFIG_CLOCK <= 1'b0;
      O_CONFIG_CLOCK_OE <= 1'b0;
      O_DONE <= 1'b0;
      O_IO_PULLUP <= 1'b0;
      O_MODE_PULLUP <= 1'b1;
      O_TEST_PORT_EN <= 1'b1;
    end else begin
      O_INIT_N <= 1'b0;
      O_INIT_N_OE <= state_q == ST_HOLD || state_q == ST_CLEAR || state_q == ST_FINAL || state_q == ST_ERROR;
      O_CONFIG_CLOCK <= clk_run ? (bit_edge ? 1'b1 : mclk_q && !(div_q >= half_q - 8'h01)) : 1'b0;
      O_CONFIG_CLOCK_OE <= master && state_q != ST_HOLD && state_q != ST_CLEAR;
      O_DONE <= state_q == ST_RUN;
      O_IO_PULLUP <= !mode_s2_q[2] && state_q != ST_RUN;
      O_MODE_PULLUP <= 1'b1;
      O_TEST_PORT_EN <= 1'b1;
    end
  end

  // Daisy chain: bits beyond our own frame go out one system cycle after the rising edge that captures them.
  always_ff @(posedge I_CLK) begin
    if (I_RST || state_q == ST_HOLD) begin
      O_CHAIN_DATA <= 1'b1;
    end else if (bit_edge && (state_q == ST_CHECK || state_q == ST_RUN || state_q == ST_ERROR)) begin
      O_CHAIN_DATA <= din_s2_q;
    end
  end

  // Avalon slave: every access answers on the second edge, one cycle of waitrequest low.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wait_q <= 1'b1;
      O_AVS_READDATA <= 32'h0;
    end else if ((I_AVS_READ || I_AVS_WRITE) && wait_q) begin
      wait_q <= 1'b0;
      case (I_AVS_ADDRESS)
        `CFG_ADDR_STATUS: begin
          O_AVS_READDATA <= {21'h0, 3'(state_q), 1'b0, init_s2_q, crc_err_q, O_DONE, !mode_pins_q[2], mode_pins_q};
        end
        `CFG_ADDR_RATE: O_AVS_READDATA <= {24'h0, half_q};
        `CFG_ADDR_BITCNT: O_AVS_READDATA <= bit_cnt_q;
        default: O_AVS_READDATA <= 32'h0;
      endcase
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign O_AVS_WAITREQUEST = wait_q;

  // A control write with bit 0 set acts as a one-cycle reprogram pulse, taken as the write completes.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      reprog_q <= 1'b0;
    end else begin
      reprog_q <= I_AVS_WRITE && !wait_q && I_AVS_ADDRESS == `CFG_ADDR_CTRL && I_AVS_WRITEDATA[`CFG_CTRL_REPROG_BIT];
    end
  end

  sequence s_final_end;
    state_q == ST_FINAL && cyc_q == 16'(FINAL_CYCLES - 1) && prog_s2_q && !reprog_q;
  endsequence

  sequence s_released;
    state_q == ST_WAIT_INIT ##1 !O_INIT_N_OE;
  endsequence

  a_clear_then_release: assert property (@(posedge I_CLK) disable iff (I_RST) s_final_end |=> s_released)
    else $error("init status not released after final clearing pass");
  a_init_low_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q == ST_CLEAR |=> O_INIT_N_OE && !O_INIT_N)
    else $error("init status not driven low while clearing");
  a_no_load_init_low: assert property (@(posedge I_CLK) disable iff (I_RST)
    !init_s2_q |=> $stable(bit_cnt_q) || state_q != ST_LOAD)
    else $error("bit loaded while init status low");
  a_crc_fail_init: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q == ST_CHECK && !crc_ok && prog_s2_q && !reprog_q |=> ##1 O_INIT_N_OE)
    else $error("crc failure did not drive init status low");
  a_crc_pass_done: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q == ST_CHECK && crc_ok && prog_s2_q && !reprog_q |=> ##1 O_DONE)
    else $error("passing check did not raise completion");
  a_rate_only_up: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q != ST_HOLD && state_q != ST_CLEAR && $past(state_q) != ST_HOLD |-> half_q <= $past(half_q))
    else $error("master clock rate decreased");
  a_rate_ceiling: assert property (@(posedge I_CLK) disable iff (I_RST) half_q >= MIN_HALF)
    else $error("master clock rate above ceiling");
  a_mode_held: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q == ST_LOAD && $past(state_q) == ST_LOAD |-> $stable(mode_q))
    else $error("mode changed during loading");
  a_chain_one_later: assert property (@(posedge I_CLK) disable iff (I_RST)
    bit_edge && state_q == ST_RUN |=> O_CHAIN_DATA == $past(din_s2_q))
    else $error("chain output not the previous input bit");
  a_chain_rise_only: assert property (@(posedge I_CLK) disable iff (I_RST)
    !bit_edge && state_q != ST_HOLD |=> $stable(O_CHAIN_DATA))
    else $error("chain output changed off a rising edge");
  a_mode_decode: assert property (@(posedge I_CLK) disable iff (I_RST)
    s_final_end ##1 mode_pins_q[1:0] == 2'h3 |-> mode_q == MODE_SLAVE_SERIAL)
    else $error("slave-serial code decoded wrongly");
  // A reprogram request stops the master clock, so a loading phase cut short is not a stuck clock.
  a_master_clock_out: assert property (@(posedge I_CLK) disable iff (I_RST)
    master && state_q == ST_LOAD |-> ##[1:40] (O_CONFIG_CLOCK || state_q == ST_HOLD))
    else $error("master clock not toggling");

  // The clock pin is driven only in master mode, and before start-up the I/O pull-up follows the top mode pin.
  a_clock_drive_mode: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q != ST_HOLD && state_q != ST_CLEAR |=> O_CONFIG_CLOCK_OE == $past(master))
    else $error("clock pin drive does not follow master mode");
  a_io_pullup_low: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q != ST_RUN && !mode_s2_q[2] |=> O_IO_PULLUP)
    else $error("pull-up not applied with top mode pin low");
endmodule : serial_config_mode_loader

// File: testbench/serial_config_mode_loader_bench.sv
// Purpose: Self-checking bench for the serial configuration loader.
// Assumes: 50 MHz system clock and a short frame of 64 bits.
// Notes: The init and clock wires are resolved here from all parties.
`timescale 1ns/10ps
`include "serial_config_mode_loader_regs.svh"
module serial_config_mode_loader_bench;
  import serial_config_mode_loader_pkg::*;
  localparam int FRAME = 64;
  localparam int LIMIT = 30000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic program_n = 1'b0;
  logic hold_q = 1'b0;
  logic master_q = 1'b0;
  logic start_q = 1'b0;
  logic [2:0] mode_q = 3'h7;
  logic [79:0] bits_q = '0;
  logic [6:0] count_q = 7'h00;
  logic [3:0] address = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, r;
  logic init_n, pin_clock, link_clock, sdata, busy, waitrequest, init_oe, config_clock, config_clock_oe;
  logic chain, done, io_pullup, mode_pullup, test_en, init_out;
  logic link_d = 1'b0;
  logic chain_seen[$];
  int halves[$];
  int phase = 0;
  int hi = 0;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  assign init_n = !(init_oe && !init_out) && !hold_q;
  assign pin_clock = config_clock_oe ? config_clock : link_clock;
  serial_config_mode_loader #(.FRAME_BITS(FRAME)) u_dut (.I_CLK(clk), .I_RST(rst),
    .I_MODE_PIN_HIGH(mode_q[2]), .I_MODE_PIN_MID(mode_q[1]), .I_MODE_PIN_LOW(mode_q[0]),
    .I_PROGRAM_N(program_n), .I_INIT_N(init_n), .I_CONFIG_CLOCK(pin_clock), .I_SERIAL_DATA(sdata),
    .I_AVS_ADDRESS(address), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitrequest), .O_INIT_N(init_out), .O_INIT_N_OE(init_oe),
    .O_CONFIG_CLOCK(config_clock), .O_CONFIG_CLOCK_OE(config_clock_oe), .O_CHAIN_DATA(chain), .O_DONE(done),
    .O_IO_PULLUP(io_pullup), .O_MODE_PULLUP(mode_pullup), .O_TEST_PORT_EN(test_en));
  serial_source_model u_src (.i_clk(clk), .i_rst(rst), .i_master(master_q), .i_dev_clock(config_clock),
    .i_init_n(init_n), .i_done(done), .i_start(start_q), .i_bits(bits_q), .i_count(count_q),
    .o_link_clock(link_clock), .o_data(sdata), .o_busy(busy));
  // Chain output is sampled mid-bit; master clock high times are recorded.
  always @(posedge clk) begin
    link_d <= link_clock;
    phase <= (link_clock && !link_d) ? 0 : phase + 1;
    if (phase == 4) chain_seen.push_back(chain);
    hi <= config_clock ? hi + 1 : 0;
    if (!config_clock && hi != 0) halves.push_back(hi);
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic bus(input logic write, input logic [3:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk);
    address <= addr;
    wdata <= data;
    wr <= write;
    rd <= !write;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    r = rdata;
    check("bus answer edges", 32'd2, n);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wait_release(output int n);
    n = 0;
    while (init_oe !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_release
  task automatic restart(input logic [2:0] m);
    int n;
    mode_q <= m;
    bus(1'b1, `CFG_ADDR_CTRL, 32'h1);
    bus(1'b1, `CFG_ADDR_CTRL, 32'h0);
    wait_release(n);
    check("init release", 32'h0, init_oe);
    repeat (8) @(posedge clk);
  endtask : restart
  task automatic send(input logic m, input logic [79:0] b, input logic [6:0] k);
    int n;
    n = 0;
    master_q <= m;
    bits_q <= b;
    count_q <= k;
    start_q <= 1'b1;
    chain_seen.delete();
    halves.delete();
    @(posedge clk);
    start_q <= 1'b0;
    @(posedge clk);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
  endtask : send
  function automatic logic [63:0] make_frame(input logic [7:0] rate, input logic [39:0] body);
    logic [15:0] crc;
    logic [47:0] pre;
    logic fb;
    pre = {rate, body};
    crc = `CFG_CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      fb = crc[15] ^ pre[i];
      crc = {crc[14:0], 1'b0} ^ (fb ? `CFG_CRC_POLY : 16'h0000);
    end
    return {pre, crc};
  endfunction : make_frame
  task automatic test_power_up();
    int n;
    repeat (100) @(posedge clk);
    check("init held by program", 32'h1, init_oe);
    check("mode pull-ups", 32'h1, mode_pullup);
    program_n <= 1'b1;
    wait_release(n);
    check("clear length", 32'h1, (n >= 80) && (n <= 92));
    repeat (8) @(posedge clk);
    bus(1'b0, `CFG_ADDR_STATUS, 32'h0);
    check("default mode", 32'h7, r[2:0]);
  endtask : test_power_up
  task automatic test_modes();
    for (int c = 0; c < 8; c++) begin
      restart(c[2:0]);
      bus(1'b0, `CFG_ADDR_STATUS, 32'h0);
      check("mode code", c, r[2:0]);
      check("pull-up flag", !c[2], r[3]);
      check("io pull-up", !c[2], io_pullup);
      check("master clock drive", c[1:0] == 2'b00, config_clock_oe);
      check("loading", (c[1:0] == 2'b00) || (c[1:0] == 2'b11), r[10:8] == ST_LOAD);
      check("test port", 32'h1, test_en);
      mode_q <= ~c[2:0];
      repeat (8) @(posedge clk);
      bus(1'b0, `CFG_ADDR_STATUS, 32'h0);
      check("latched mode", c, r[2:0]);
    end
    bus(1'b0, 4'h1, 32'h0);
    check("unmapped read", 32'h0, r);
  endtask : test_modes
  task automatic test_init_hold();
    hold_q <= 1'b1;
    restart(3'h7);
    send(1'b0, {16'hffff, 64'h0}, 7'd16);
    bus(1'b0, `CFG_ADDR_BITCNT, 32'h0);
    check("bits while held", 32'h0, r);
    check("done while held", 32'h0, done);
    hold_q <= 1'b0;
  endtask : test_init_hold
  task automatic test_slave(input logic bad, input logic [2:0] m);
    logic [63:0] f;
    f = make_frame(8'h00, 40'h5ac3960fe1);
    restart(m);
    send(1'b0, {f ^ {43'h0, bad, 20'h0}, 16'hb38d}, 7'd80);
    check("done", !bad, done);
    check("init error", bad, init_oe);
    bus(1'b0, `CFG_ADDR_STATUS, 32'h0);
    check("crc flag", bad, r[5]);
    for (int k = 64; k < 80 && !bad; k++) begin
      check("chain bit", 16'hb38d >> (79 - k) & 16'h1, chain_seen[k]);
    end
  endtask : test_slave
  task automatic test_master(input logic [7:0] field, input int half);
    logic [63:0] f;
    f = make_frame(field, 40'h13579bdf02);
    restart(3'h4);
    send(1'b1, {f, 16'h0}, 7'd64);
    if (field == 8'h14) check("slow half period", 32'd10, halves[1]);
    check("final half period", half, halves[halves.size() - 1]);
    check("master done", 32'h1, done);
    bus(1'b0, `CFG_ADDR_RATE, 32'h0);
    check("rate field", half, r[7:0]);
  endtask : test_master
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_power_up();
    test_modes();
    test_init_hold();
    test_slave(1'b0, 3'h3);
    test_slave(1'b1, 3'h7);
    test_master(8'h14, 10);
    test_master(8'h00, 6);
    test_master(8'h04, 4);
    test_master(8'h01, 2);
    complete_run();
  end
endmodule : serial_config_mode_loader_bench

// File: testbench/serial_source_model.sv
// Purpose: Serial source model, a PROM or upstream device feeding the loader.
// Assumes: Slave link clock is 8 system cycles a period; master mode follows the device clock.
// Notes: Data changes every cycle while no stream runs, so stale bits are never mistaken for data.
`timescale 1ns/10ps
module serial_source_model (
  input wire logic i_clk, // System clock.
  input wire logic i_rst, // Reset.
  input wire logic i_master, // Follow the device clock.
  input wire logic i_dev_clock, // Device clock out.
  input wire logic i_init_n, // Init wire level.
  input wire logic i_done, // Completion pin.
  input wire logic i_start, // Begin a stream.
  input wire logic [79:0] i_bits, // Stream, first bit on top.
  input wire logic [6:0] i_count, // Bits to send.
  output logic o_link_clock, // Slave link clock.
  output logic o_data, // Serial data.
  output logic o_busy // Stream running.
);
  logic [79:0] shift_q;
  logic [6:0] sent_q;
  logic [2:0] phase_q;
  logic dev_q;
  always_ff @(posedge i_clk) begin
    dev_q <= i_dev_clock;
    if (i_rst) begin
      o_busy <= 1'b0;
      o_link_clock <= 1'b0;
      o_data <= 1'b0;
    end else if (i_start) begin
      o_busy <= 1'b1;
      shift_q <= i_bits;
      sent_q <= 7'h00;
      phase_q <= 3'h0;
      o_data <= i_bits[79];
    end else if (!o_busy || (i_master && i_done)) begin
      o_busy <= 1'b0;
      o_link_clock <= 1'b0;
      o_data <= ~o_data;
    end else if (i_master && !i_init_n) begin
      shift_q <= i_bits;
      sent_q <= 7'h00;
      o_data <= i_bits[79];
    end else if (i_master ? (i_dev_clock && !dev_q) : (phase_q == 3'h7)) begin
      o_link_clock <= 1'b0;
      shift_q <= {shift_q[78:0], 1'b0};
      o_data <= shift_q[78];
      sent_q <= sent_q + 7'h01;
      o_busy <= (sent_q + 7'h01 != i_count);
      phase_q <= 3'h0;
    end else begin
      phase_q <= phase_q + 3'h1;
      o_link_clock <= (phase_q >= 3'h3) && !i_master;
    end
  end
endmodule : serial_source_model
